// >>> inc/caod_pkg.sv
package caod_pkg;

  // Field positions inside the 32-bit instruction word.
  localparam int unsigned FLD_HI_LSB   = 16;
  localparam int unsigned FLD_MID_LSB  = 21;
  localparam int unsigned FLD_IDX_LSB  = 0;
  localparam int unsigned FLD_PTR_LSB  = 5;
  localparam int unsigned FLD_REV_BIT  = 10;
  localparam int unsigned FLD_DIR_BIT  = 24;
  localparam int unsigned FLD_SIZE_LSB = 22;
  localparam int unsigned FLD_UPB_LSB  = 21;
  localparam int unsigned IMM16_W      = 16;
  localparam int unsigned IMM24_W      = 24;
  localparam int unsigned UPB_W        = 8;

  // Operand kinds produced by the decoder.
  typedef enum logic [3:0] {
    CAOD_K_ZERO  = 4'h0,
    CAOD_K_GPR   = 4'h1,
    CAOD_K_PC    = 4'h2,
    CAOD_K_DEC   = 4'h3,
    CAOD_K_INC   = 4'h4,
    CAOD_K_SIN   = 4'h5,
    CAOD_K_SOUT  = 4'h6,
    CAOD_K_FUC   = 4'h7,
    CAOD_K_IOC   = 4'h8,
    CAOD_K_VTP   = 4'h9,
    CAOD_K_SPC   = 4'hA,
    CAOD_K_FMT7C = 4'hB,
    CAOD_K_RSVD  = 4'hF
  } caod_kind_e;

  // Register-direct I/O targets.
  typedef enum logic [3:0] {
    CAOD_IO_NONE = 4'h0,
    CAOD_IO_SRX  = 4'h1,
    CAOD_IO_STX  = 4'h2,
    CAOD_IO_PDW  = 4'h3,
    CAOD_IO_PIOP = 4'h4,
    CAOD_IO_PDW2 = 4'h5,
    CAOD_IO_PIW  = 4'h6,
    CAOD_IO_PCW  = 4'h7,
    CAOD_IO_BKP  = 4'h8
  } caod_io_e;

  // Data move sizes.
  typedef enum logic [1:0] {
    CAOD_SZ_HIB  = 2'h0,
    CAOD_SZ_LOB  = 2'h1,
    CAOD_SZ_INT  = 2'h2,
    CAOD_SZ_WORD = 2'h3
  } caod_size_e;

  // Step magnitudes for float, integer and byte.
  localparam logic [2:0] STEP_FLT  = 3'h4;
  localparam logic [2:0] STEP_INT  = 3'h2;
  localparam logic [2:0] STEP_BYTE = 3'h1;

  // Select codes.
  localparam logic [4:0] C_ZERO_A = 5'h00;
  localparam logic [4:0] C_R14    = 5'h0E;
  localparam logic [4:0] C_PC     = 5'h0F;
  localparam logic [4:0] C_ZERO_B = 5'h10;
  localparam logic [4:0] C_R15    = 5'h11;
  localparam logic [4:0] C_R19    = 5'h15;
  localparam logic [4:0] C_DEC    = 5'h16;
  localparam logic [4:0] C_INC    = 5'h17;
  localparam logic [4:0] C_SIN    = 5'h18;
  localparam logic [4:0] C_SOUT   = 5'h19;
  localparam logic [4:0] C_FUC    = 5'h1A;
  localparam logic [4:0] C_IOC    = 5'h1B;
  localparam logic [4:0] C_VTP    = 5'h1D;
  localparam logic [4:0] C_SPC    = 5'h1E;
  localparam logic [4:0] C_IO_SRX  = 5'h04;
  localparam logic [4:0] C_IO_STX  = 5'h05;
  localparam logic [4:0] C_IO_PDW  = 5'h06;
  localparam logic [4:0] C_IO_BKP  = 5'h0A;
  localparam logic [4:0] C_IO_PIOP = 5'h0E;
  localparam logic [4:0] C_IO_PDW2 = 5'h14;
  localparam logic [4:0] C_IO_PIW  = 5'h16;
  localparam logic [4:0] C_IO_PCW  = 5'h1E;

endpackage

// >>> inc/caod_sel_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries one register-select field and its decoded meaning.
interface caod_sel_if;
  logic [4:0]          code;
  logic [1:0]          mode;
  logic [1:0]          size;
  caod_pkg::caod_kind_e kind;
  logic [4:0]          gpr;
  logic signed [3:0]   step;
  modport dec (input code, input mode, input size, output kind, output gpr, output step);
  modport use_ (output code, output mode, output size, input kind, input gpr, input step);
endinterface
`default_nettype wire

// >>> verilog/caod_field_dec.sv
`timescale 1ns/1ps
`default_nettype none
// Combinational decoder for one five-bit select field; mode 0 = S/D/M/H,
// mode 1 = pointer field, mode 2 = index field.
module caod_field_dec (
  caod_sel_if.dec s
);

  // General register number for the two register ranges.
  function automatic logic [4:0] gpr_num(input logic [4:0] c);
    if (c >= 5'h01 && c <= caod_pkg::C_R14) begin
      gpr_num = c;
    end else begin
      gpr_num = 5'(c - 5'h02);
    end
  endfunction

  wire logic       low_rng  = (s.code >= 5'h01) && (s.code <= caod_pkg::C_R14);
  wire logic       high_rng = (s.code >= caod_pkg::C_R15) && (s.code <= caod_pkg::C_R19);
  wire logic       is_sel   = (s.mode == 2'h0);
  wire logic       is_ptr   = (s.mode == 2'h1);
  // A full word steps as float, an integer by two and either byte size by one.
  wire logic [2:0] mag      = (s.size == 2'h3) ? caod_pkg::STEP_FLT :
                              (s.size == 2'h2) ? caod_pkg::STEP_INT : caod_pkg::STEP_BYTE;

  // Index field has no float step, so a full word steps like an integer.
  wire logic [2:0] idx_mag  = s.size[1] ? caod_pkg::STEP_INT : caod_pkg::STEP_BYTE;
  wire logic [2:0] use_mag  = is_sel ? mag : idx_mag;

  // Kind selection per field mode.
  always_comb begin
    s.kind = caod_pkg::CAOD_K_RSVD;
    s.gpr  = 5'h00;
    s.step = 4'sh0;
    if (low_rng || high_rng) begin
      s.kind = caod_pkg::CAOD_K_GPR;
      s.gpr  = gpr_num(s.code);
    end else begin
      case (s.code)
        caod_pkg::C_ZERO_A: begin
          s.kind = is_sel ? caod_pkg::CAOD_K_ZERO :
                   is_ptr ? caod_pkg::CAOD_K_FMT7C : caod_pkg::CAOD_K_RSVD;
        end
        caod_pkg::C_ZERO_B: begin
          s.kind = is_ptr ? caod_pkg::CAOD_K_RSVD : caod_pkg::CAOD_K_ZERO;
        end
        caod_pkg::C_PC: begin
          s.kind = is_sel ? caod_pkg::CAOD_K_PC : caod_pkg::CAOD_K_RSVD;
        end
        caod_pkg::C_DEC: begin
          s.kind = is_ptr ? caod_pkg::CAOD_K_RSVD : caod_pkg::CAOD_K_DEC;
          s.step = is_ptr ? 4'sh0 : -$signed({1'b0, use_mag});
        end
        caod_pkg::C_INC: begin
          s.kind = is_ptr ? caod_pkg::CAOD_K_RSVD : caod_pkg::CAOD_K_INC;
          s.step = is_ptr ? 4'sh0 : $signed({1'b0, use_mag});
        end
        caod_pkg::C_SIN: begin
          s.kind = caod_pkg::CAOD_K_SIN;
        end
        caod_pkg::C_SOUT: begin
          s.kind = caod_pkg::CAOD_K_SOUT;
        end
        caod_pkg::C_FUC: begin
          s.kind = is_sel ? caod_pkg::CAOD_K_FUC : caod_pkg::CAOD_K_RSVD;
        end
        caod_pkg::C_IOC: begin
          s.kind = is_sel ? caod_pkg::CAOD_K_IOC : caod_pkg::CAOD_K_RSVD;
        end
        caod_pkg::C_VTP: begin
          s.kind = caod_pkg::CAOD_K_VTP;
        end
        caod_pkg::C_SPC: begin
          s.kind = is_sel ? caod_pkg::CAOD_K_SPC : caod_pkg::CAOD_K_RSVD;
        end
        default: begin
          s.kind = caod_pkg::CAOD_K_RSVD;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> verilog/caod_decode.sv
// Behaviour
// - Select codes 0 and 16 give zero, 1-14/17-21 registers, 15 program counter.
// - Select codes 22/23 give size-based steps; 24-27, 29, 30 special registers.
// - Pointer codes pick registers and pointers; code 0 selects register-direct I/O.
// - Index code 16 is zero, 22/23 are steps, 0 reserved.
// - Reverse flag selects bit-reversed pointer update with the index register.
// - Sixteen-bit immediate is data or a memory address by format.
// - Upper immediate byte sits above the sixteen-bit immediate as one value.
// - Register-direct codes select seven I/O registers; other codes reserved.
// - Register-direct code 10 is the breakpoint access, not a register.
// - Size field selects high byte, low byte, integer or full word.
// - Direction bit 0 loads register from memory, 1 stores to memory.
`timescale 1ns/1ps
`default_nettype none
module caod_decode (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 instr_valid,
  input  wire logic [31:0]          instr,
  input  wire logic                 is_move_fmt,
  input  wire logic                 is_ptr_fmt,
  input  wire logic                 imm_is_addr,
  input  wire logic                 is_imm24,
  output logic                      dec_valid,
  output caod_pkg::caod_kind_e      dst_kind,
  output logic [4:0]                dst_gpr,
  output logic signed [3:0]         dst_step,
  output caod_pkg::caod_kind_e      src_kind,
  output logic [4:0]                src_gpr,
  output logic signed [3:0]         src_step,
  output caod_pkg::caod_kind_e      ptr_kind,
  output logic [4:0]                ptr_gpr,
  output caod_pkg::caod_kind_e      idx_kind,
  output logic [4:0]                idx_gpr,
  output logic signed [3:0]         idx_step,
  output caod_pkg::caod_io_e        io_sel,
  output logic                      bit_reverse,
  output caod_pkg::caod_size_e      move_size,
  output logic                      move_store,
  output logic [23:0]               imm_data,
  output logic [23:0]               mem_addr,
  output logic                      illegal,
  output logic                      reg_write_ok
);

  // Field extraction.
  wire logic [4:0] f_hi   = instr[caod_pkg::FLD_HI_LSB +: 5];
  wire logic [4:0] f_mid  = instr[caod_pkg::FLD_MID_LSB +: 5];
  wire logic [4:0] f_ptr  = instr[caod_pkg::FLD_PTR_LSB +: 5];
  wire logic [4:0] f_idx  = instr[caod_pkg::FLD_IDX_LSB +: 5];
  wire logic [1:0] f_size = instr[caod_pkg::FLD_SIZE_LSB +: 2];
  wire logic       f_dir  = instr[caod_pkg::FLD_DIR_BIT];
  wire logic       f_rev  = instr[caod_pkg::FLD_REV_BIT];
  wire logic [15:0] f_n   = instr[0 +: caod_pkg::IMM16_W];
  wire logic [7:0]  f_ne  = instr[caod_pkg::FLD_UPB_LSB +: caod_pkg::UPB_W];

  caod_sel_if dsel ();
  caod_sel_if ssel ();
  caod_sel_if psel ();
  caod_sel_if isel ();

  // Destination is the H field; source is the M field.
  assign dsel.code = f_hi;
  assign dsel.mode = 2'h0;
  assign dsel.size = f_size;
  assign ssel.code = f_mid;
  assign ssel.mode = 2'h0;
  assign ssel.size = f_size;
  assign psel.code = f_ptr;
  assign psel.mode = 2'h1;
  assign psel.size = f_size;
  assign isel.code = f_idx;
  assign isel.mode = 2'h2;
  assign isel.size = f_size;

  caod_field_dec u_dst (.s(dsel));
  caod_field_dec u_src (.s(ssel));
  caod_field_dec u_ptr (.s(psel));
  caod_field_dec u_idx (.s(isel));

  // Register-direct decode when the pointer field is zero.
  wire logic io_fmt = is_move_fmt && (psel.kind == caod_pkg::CAOD_K_FMT7C);
  wire caod_pkg::caod_io_e io_dec =
    (f_idx == caod_pkg::C_IO_SRX)  ? caod_pkg::CAOD_IO_SRX  :
    (f_idx == caod_pkg::C_IO_STX)  ? caod_pkg::CAOD_IO_STX  :
    (f_idx == caod_pkg::C_IO_PDW)  ? caod_pkg::CAOD_IO_PDW  :
    (f_idx == caod_pkg::C_IO_PIOP) ? caod_pkg::CAOD_IO_PIOP :
    (f_idx == caod_pkg::C_IO_PDW2) ? caod_pkg::CAOD_IO_PDW2 :
    (f_idx == caod_pkg::C_IO_PIW)  ? caod_pkg::CAOD_IO_PIW  :
    (f_idx == caod_pkg::C_IO_PCW)  ? caod_pkg::CAOD_IO_PCW  :
    (f_idx == caod_pkg::C_IO_BKP)  ? caod_pkg::CAOD_IO_BKP  : caod_pkg::CAOD_IO_NONE;
  wire caod_pkg::caod_io_e next_io_sel = io_fmt ? io_dec : caod_pkg::CAOD_IO_NONE;

  // Reserved-code detection across every field in use.
  wire logic sel_bad = (dsel.kind == caod_pkg::CAOD_K_RSVD) ||
                       (!is_move_fmt && ssel.kind == caod_pkg::CAOD_K_RSVD);
  wire logic ptr_bad = is_move_fmt && is_ptr_fmt && !io_fmt &&
                       (psel.kind == caod_pkg::CAOD_K_RSVD ||
                        isel.kind == caod_pkg::CAOD_K_RSVD);
  wire logic io_bad  = io_fmt && (io_dec == caod_pkg::CAOD_IO_NONE ||
                                  io_dec == caod_pkg::CAOD_IO_BKP);
  wire logic next_illegal = sel_bad || ptr_bad || io_bad;

  // Immediate assembly.
  wire logic [23:0] imm_cat = is_imm24 ? {f_ne, f_n} : {8'h00, f_n};

  // Decoded outputs are registered; clock enable freezes all state.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dec_valid <= 1'b0;
      illegal   <= 1'b0;
      imm_data  <= 24'h000000;
      mem_addr  <= 24'h000000;
    end else if (ce) begin
      dec_valid <= instr_valid;
      illegal   <= instr_valid && next_illegal;
      imm_data  <= imm_is_addr ? 24'h000000 : imm_cat;
      mem_addr  <= imm_is_addr ? imm_cat : 24'h000000;
    end
  end

  // Operand descriptors.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dst_kind <= caod_pkg::CAOD_K_ZERO;
      dst_gpr  <= 5'h00;
      dst_step <= 4'sh0;
      src_kind <= caod_pkg::CAOD_K_ZERO;
      src_gpr  <= 5'h00;
      src_step <= 4'sh0;
    end else if (ce) begin
      dst_kind <= dsel.kind;
      dst_gpr  <= dsel.gpr;
      dst_step <= dsel.step;
      src_kind <= ssel.kind;
      src_gpr  <= ssel.gpr;
      src_step <= ssel.step;
    end
  end

  // Pointer, index and move controls.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr_kind    <= caod_pkg::CAOD_K_ZERO;
      ptr_gpr     <= 5'h00;
      idx_kind    <= caod_pkg::CAOD_K_ZERO;
      idx_gpr     <= 5'h00;
      idx_step    <= 4'sh0;
      io_sel      <= caod_pkg::CAOD_IO_NONE;
      bit_reverse <= 1'b0;
      move_size   <= caod_pkg::CAOD_SZ_HIB;
      move_store  <= 1'b0;
    end else if (ce) begin
      ptr_kind    <= psel.kind;
      ptr_gpr     <= psel.gpr;
      idx_kind    <= isel.kind;
      idx_gpr     <= isel.gpr;
      idx_step    <= isel.step;
      io_sel      <= next_io_sel;
      bit_reverse <= is_ptr_fmt && f_rev;
      move_size   <= caod_pkg::caod_size_e'(f_size);
      move_store  <= f_dir;
    end
  end

  // Register writes are allowed only for legal, valid instructions.
  assign reg_write_ok = dec_valid && !illegal;

  // Checks start only on edges where reset was already low, as the flops saw it.
  wire logic ce_live = ce && !rst;

  // Reserved codes must raise the illegal flag one cycle later.
  property p_illegal_flag;
    @(posedge sys_clk) disable iff (rst)
      (ce_live && instr_valid && next_illegal) |=> illegal;
  endproperty
  a_illegal_flag_set: assert property (p_illegal_flag)
    else $error("reserved code did not flag illegal");

  a_no_write_illegal: assert property (@(posedge sys_clk) disable iff (rst)
    (ce_live && !(instr_valid && !next_illegal)) |=> !reg_write_ok)
    else $error("write allowed on illegal code");

  a_pc_select: assert property (@(posedge sys_clk) disable iff (rst)
    (ce_live && f_hi == caod_pkg::C_PC) |=> dst_kind == caod_pkg::CAOD_K_PC)
    else $error("program counter code misdecoded");

  a_step_sign: assert property (@(posedge sys_clk) disable iff (rst)
    (ce_live && f_hi == caod_pkg::C_DEC && f_size == 2'h3) |=> dst_step == -4'sh4)
    else $error("float decrement step wrong");

  a_ptr_io_fmt: assert property (@(posedge sys_clk) disable iff (rst)
    (ce_live && f_ptr == 5'h00) |=> ptr_kind == caod_pkg::CAOD_K_FMT7C)
    else $error("pointer zero did not select io format");

  a_idx_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (ce_live && f_idx == caod_pkg::C_ZERO_B) |=> idx_kind == caod_pkg::CAOD_K_ZERO)
    else $error("index zero code misdecoded");

  a_rev_flag: assert property (@(posedge sys_clk) disable iff (rst)
    (ce_live && is_ptr_fmt) |=> bit_reverse == $past(f_rev))
    else $error("bit reverse flag not followed");

  a_imm24_cat: assert property (@(posedge sys_clk) disable iff (rst)
    (ce_live && is_imm24 && !imm_is_addr) |=> imm_data[23:16] == $past(f_ne))
    else $error("upper immediate byte misplaced");

  a_bkp_reserved: assert property (@(posedge sys_clk) disable iff (rst)
    (ce_live && instr_valid && io_fmt && f_idx == caod_pkg::C_IO_BKP) |=> illegal)
    else $error("breakpoint code treated as register");

endmodule
`default_nettype wire

// >>> test/test_ctrl_arith_operand_decode.sv
`timescale 1ns/1ps
`default_nettype none
module test_ctrl_arith_operand_decode;
  typedef struct packed {
    logic [31:0] ins;
    logic        mv;
    logic        pf;
    logic        ad;
    logic        i24;
    logic        v;
    logic        c;
    logic        chk_ill;
  } caod_note_s;

  logic                 sys_clk, rst, ce, instr_valid, is_move_fmt, is_ptr_fmt;
  logic                 imm_is_addr, is_imm24;
  logic [31:0]          instr, r, ins;
  logic [4:0]           c5;
  logic                 dec_valid, bit_reverse, move_store, illegal, reg_write_ok;
  caod_pkg::caod_kind_e dst_kind, src_kind, ptr_kind, idx_kind;
  logic [4:0]           dst_gpr, src_gpr, ptr_gpr, idx_gpr;
  logic signed [3:0]    dst_step, src_step, idx_step;
  caod_pkg::caod_io_e   io_sel;
  caod_pkg::caod_size_e move_size;
  logic [23:0]          imm_data, mem_addr;
  caod_note_s           q[$];
  caod_note_s           cur, last;
  int                   errors, n_compared;

  caod_decode dut_u (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .instr_valid(instr_valid), .instr(instr),
    .is_move_fmt(is_move_fmt), .is_ptr_fmt(is_ptr_fmt), .imm_is_addr(imm_is_addr),
    .is_imm24(is_imm24), .dec_valid(dec_valid), .dst_kind(dst_kind), .dst_gpr(dst_gpr),
    .dst_step(dst_step), .src_kind(src_kind), .src_gpr(src_gpr), .src_step(src_step),
    .ptr_kind(ptr_kind), .ptr_gpr(ptr_gpr), .idx_kind(idx_kind), .idx_gpr(idx_gpr),
    .idx_step(idx_step), .io_sel(io_sel), .bit_reverse(bit_reverse), .move_size(move_size),
    .move_store(move_store), .imm_data(imm_data), .mem_addr(mem_addr), .illegal(illegal),
    .reg_write_ok(reg_write_ok)
  );

  // The clock runs at 100 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Pseudo-random source for instruction words and qualifiers.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected kind of a select code; m is 0 for register fields, 1 pointer, 2 index.
  function automatic caod_pkg::caod_kind_e kind_of(input logic [4:0] c, input int m);
    kind_of = caod_pkg::CAOD_K_RSVD;
    if ((c >= 5'h01 && c <= 5'h0E) || (c >= 5'h11 && c <= 5'h15)) kind_of = caod_pkg::CAOD_K_GPR;
    else if (c == 5'h18) kind_of = caod_pkg::CAOD_K_SIN;
    else if (c == 5'h19) kind_of = caod_pkg::CAOD_K_SOUT;
    else if (c == 5'h1D) kind_of = caod_pkg::CAOD_K_VTP;
    else if (c == 5'h00 && m == 1) kind_of = caod_pkg::CAOD_K_FMT7C;
    else if ((c == 5'h00 && m == 0) || (c == 5'h10 && m != 1)) kind_of = caod_pkg::CAOD_K_ZERO;
    else if (c == 5'h16 && m != 1) kind_of = caod_pkg::CAOD_K_DEC;
    else if (c == 5'h17 && m != 1) kind_of = caod_pkg::CAOD_K_INC;
    else if (c == 5'h0F && m == 0) kind_of = caod_pkg::CAOD_K_PC;
    else if (c == 5'h1A && m == 0) kind_of = caod_pkg::CAOD_K_FUC;
    else if (c == 5'h1B && m == 0) kind_of = caod_pkg::CAOD_K_IOC;
    else if (c == 5'h1E && m == 0) kind_of = caod_pkg::CAOD_K_SPC;
  endfunction

  // Step size and sign; the index field never steps by four.
  function automatic logic signed [3:0] step_of(input logic [4:0] c, input logic [1:0] sz,
                                                input int m);
    int mag;
    mag = (m == 2) ? (sz[1] ? 2 : 1) : ((sz == 2'h3) ? 4 : (sz == 2'h2) ? 2 : 1);
    return (c == 5'h16) ? 4'(-mag) : 4'(mag);
  endfunction

  // Register-direct target of a code; codes other than the eight listed give no target.
  function automatic caod_pkg::caod_io_e io_of(input logic [4:0] c);
    case (c)
      5'h04: io_of = caod_pkg::CAOD_IO_SRX;
      5'h05: io_of = caod_pkg::CAOD_IO_STX;
      5'h06: io_of = caod_pkg::CAOD_IO_PDW;
      5'h0A: io_of = caod_pkg::CAOD_IO_BKP;
      5'h0E: io_of = caod_pkg::CAOD_IO_PIOP;
      5'h14: io_of = caod_pkg::CAOD_IO_PDW2;
      5'h16: io_of = caod_pkg::CAOD_IO_PIW;
      5'h1E: io_of = caod_pkg::CAOD_IO_PCW;
      default: io_of = caod_pkg::CAOD_IO_NONE;
    endcase
  endfunction

  // Compares one value and reports a mismatch at once.
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares a decoded select; number and step only where the kind carries them.
  task automatic cmp_sel(input caod_pkg::caod_kind_e k, input logic [4:0] g,
                         input logic signed [3:0] s, input logic [4:0] c,
                         input logic [1:0] sz, input int m);
    caod_pkg::caod_kind_e ek;
    ek = kind_of(c, m);
    cmp(24'(k), 24'(ek));
    if (ek == caod_pkg::CAOD_K_GPR) cmp(24'(g), 24'((c <= 5'h0E) ? c : c - 5'h02));
    if (ek == caod_pkg::CAOD_K_DEC || ek == caod_pkg::CAOD_K_INC) cmp(24'(s), 24'(step_of(c, sz, m)));
  endtask

  // Checks every decoded output against one noted instruction.
  task automatic check(input caod_note_s n);
    logic [23:0] imm;
    logic [4:0]  p;
    logic        ill;
    p = n.ins[9:5];
    imm = n.i24 ? {n.ins[28:21], n.ins[15:0]} : {8'h00, n.ins[15:0]};
    ill = kind_of(n.ins[20:16], 0) == caod_pkg::CAOD_K_RSVD
        || (!n.mv && kind_of(n.ins[25:21], 0) == caod_pkg::CAOD_K_RSVD)
        || (n.mv && n.pf && p != 5'h00 && kind_of(p, 1) == caod_pkg::CAOD_K_RSVD)
        || (n.pf && kind_of(n.ins[4:0], 2) == caod_pkg::CAOD_K_RSVD)
        || (n.mv && p == 5'h00 && io_of(n.ins[4:0]) inside {caod_pkg::CAOD_IO_NONE,
                                                             caod_pkg::CAOD_IO_BKP});
    cmp_sel(dst_kind, dst_gpr, dst_step, n.ins[20:16], n.ins[23:22], 0);
    cmp_sel(src_kind, src_gpr, src_step, n.ins[25:21], n.ins[23:22], 0);
    cmp_sel(ptr_kind, ptr_gpr, 4'sh0, p, 2'h0, 1);
    cmp_sel(idx_kind, idx_gpr, idx_step, n.ins[4:0], n.ins[23:22], 2);
    cmp(24'(io_sel), 24'((n.mv && p == 5'h00) ? io_of(n.ins[4:0]) : caod_pkg::CAOD_IO_NONE));
    cmp(24'(bit_reverse), 24'(n.pf & n.ins[10]));
    cmp(24'(move_size), 24'(n.ins[23:22]));
    cmp(24'(move_store), 24'(n.ins[24]));
    cmp(imm_data, n.ad ? 24'h000000 : imm);
    cmp(mem_addr, n.ad ? imm : 24'h000000);
    if (n.chk_ill) begin
      cmp(24'(illegal), 24'(ill));
      cmp(24'(reg_write_ok), 24'(!ill));
    end
  endtask

  // Drives one cycle of inputs and notes it for the watcher.
  task automatic apply(input logic [31:0] w, input logic mv, pf, ad, i24, v, c);
    @(posedge sys_clk);
    instr <= w;
    is_move_fmt <= mv;
    is_ptr_fmt <= pf;
    imm_is_addr <= ad;
    is_imm24 <= i24;
    instr_valid <= v;
    ce <= c;
    q.push_back('{w, mv, pf, ad, i24, v, c, 1'b1});
  endtask

  // Outputs shown after an edge belong to the second newest note.
  always @(negedge sys_clk) begin
    if (q.size() >= 2) begin
      cur = q.pop_front();
      if (cur.c) begin
        cmp(24'(dec_valid), 24'(cur.v));
        if (cur.v) check(cur);
        last = cur;
      end else begin
        cmp(24'(dec_valid), 24'(last.v));
        if (last.v) check(last);
      end
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    test_done();
  end

  // Directed sweeps of every code in every field, a reset in mid-run, then random traffic.
  initial begin
    {rst, ce, instr_valid, is_move_fmt, is_ptr_fmt, imm_is_addr, is_imm24} = 7'h40;
    instr = 32'h00000000;
    last = '0;
    errors = 0;
    n_compared = 0;
    r = 32'h0000004F;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 32; i++) begin
        c5 = 5'(i);
        r = lfsr(r);
        case (p)
          0: ins = {r[31:26], c5, c5, r[15:0]};
          1: ins = {r[31:11], c5[0], c5, c5};
          default: ins = {r[31:10], 5'h00, c5};
        endcase
        apply(ins, p != 0, p == 1 && c5 != 5'h00, c5[1], c5[2], 1'b1, 1'b1);
      end
    end
    apply(r, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    @(posedge sys_clk);
    rst <= 1'b1;
    q.delete();
    last = '0;
    @(negedge sys_clk);
    cmp(24'(dec_valid), 24'h000000);
    cmp(24'(illegal), 24'h000000);
    cmp(24'(reg_write_ok), 24'h000000);
    @(posedge sys_clk);
    rst <= 1'b0;
    for (int k = 0; k < 300; k++) begin
      r = lfsr(r);
      ins = r;
      r = lfsr(r);
      apply(ins, r[0], r[0] && r[1] && ins[9:5] != 5'h00, r[2], r[3], r[5:4] != 2'h0,
            r[7:6] != 2'h0);
    end
    apply(r, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    apply(r, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    @(negedge sys_clk);
    test_done();
  end
endmodule
`default_nettype wire
